// file: verilog/sstp_receiver.sv
/*
  Start-stop tape punch receiver: deserialises 11-unit current-loop frames
  and punches each as one tape row, then advances the tape.
  Assumes line_current is synchronous to clk_sys (1 = current flowing).
*/
`timescale 1ns/1ps
`include "sstp_consts.svh"

module sstp_receiver
  import sstp_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    line_current,
  input  wire logic [`SSTP_CNT_W-1:0]  unit_cycles,
  input  wire logic [`SSTP_CNT_W-1:0]  sample_point,
  input  wire logic                    backspace_req,
  output logic                         punch_fire,
  output sstp_row_s                    punch_row,
  output logic                         tape_advance,
  output logic                         tape_backspace,
  output logic                         rx_busy,
  output logic                         punch_busy,
  output logic                         frame_error,
  output logic [7:0]                   last_code
);

  sstp_rx_e               rx_state;
  logic [`SSTP_CNT_W-1:0] rx_cnt;
  logic [3:0]             bit_idx;
  logic [7:0]             shift;
  logic                   mark;
  logic                   bk_prev;
  logic                   bk_pend;

  // Two-entry buffer between selector and punch
  logic [7:0]             buf_data [0:1];
  logic                   buf_wp;
  logic                   buf_rp;
  logic [1:0]             buf_cnt;
  logic                   in_valid;
  logic [7:0]             in_data;
  logic                   in_ready;
  logic                   out_valid;
  logic                   out_ready;

  sstp_pn_e               pn_state;
  logic [15:0]            pn_cnt;

  assign mark      = (line_current == `SSTP_MARK_LEVEL);
  assign in_ready  = (buf_cnt != 2'h2);
  assign out_valid = (buf_cnt != 2'h0);
  assign out_ready = (pn_state == PN_IDLE) && !bk_pend;

  function automatic logic [`SSTP_CNT_W-1:0] f_unit(input logic [`SSTP_CNT_W-1:0] u);
    f_unit = (u == '0) ? `SSTP_CNT_W'(`SSTP_UNIT_CYC) : u;
  endfunction : f_unit

  function automatic logic [`SSTP_CNT_W-1:0] f_samp(input logic [`SSTP_CNT_W-1:0] u,
                                                     input logic [`SSTP_CNT_W-1:0] s);
    // Zero selects mid-bit; otherwise clamp inside the interval
    if (s == '0)
      f_samp = f_unit(u) >> 1;
    else if (s >= f_unit(u))
      f_samp = f_unit(u) - `SSTP_CNT_W'(1);
    else
      f_samp = s;
  endfunction : f_samp

  // Selecting cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state    <= RX_IDLE;
      rx_cnt      <= '0;
      bit_idx     <= 4'h0;
      shift       <= 8'h00;
      in_valid    <= 1'b0;
      in_data     <= 8'h00;
      frame_error <= 1'b0;
      rx_busy     <= 1'b0;
    end else begin
      if (in_valid && in_ready)
        in_valid <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_busy <= 1'b0;
          if (!mark) begin
            rx_state <= RX_START;
            // Detect cycle counts as the first of the start bit, so frames do not drift
            rx_cnt   <= `SSTP_CNT_W'(1);
            rx_busy  <= 1'b1;
          end
        end
        RX_START: begin
          // Sample and end kept apart so a clamped sample point still ends the bit
          if (rx_cnt == f_samp(unit_cycles, sample_point) && mark) begin
            rx_state <= RX_IDLE; // Glitch, not a start bit
          end else if (rx_cnt == f_unit(unit_cycles) - `SSTP_CNT_W'(1)) begin
            rx_state <= RX_DATA;
            rx_cnt   <= '0;
            bit_idx  <= 4'h0;
          end else begin
            rx_cnt <= rx_cnt + `SSTP_CNT_W'(1);
          end
        end
        RX_DATA: begin
          if (rx_cnt == f_samp(unit_cycles, sample_point))
            shift <= {mark, shift[7:1]};
          if (rx_cnt == f_unit(unit_cycles) - `SSTP_CNT_W'(1)) begin
            rx_cnt  <= '0;
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == `SSTP_DATA_BITS - 4'h1) begin
              rx_state <= RX_STOP;
              bit_idx  <= 4'h0;
              // Handed over at the last cycle of the eighth data bit, before the stop bits
              if (in_ready) begin
                in_valid <= 1'b1;
                in_data  <= shift;
              end
            end
          end else begin
            rx_cnt <= rx_cnt + `SSTP_CNT_W'(1);
          end
        end
        RX_STOP: begin
          if (rx_cnt == f_samp(unit_cycles, sample_point) && !mark)
            frame_error <= 1'b1;
          if (rx_cnt == f_unit(unit_cycles) - `SSTP_CNT_W'(1)) begin
            rx_cnt  <= '0;
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == 4'(`SSTP_STOP_BITS) - 4'h1)
              rx_state <= RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt + `SSTP_CNT_W'(1);
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Buffer lets a new frame arrive while punching
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_wp      <= 1'b0;
      buf_rp      <= 1'b0;
      buf_cnt     <= 2'h0;
      buf_data[0] <= 8'h00;
      buf_data[1] <= 8'h00;
    end else begin
      if (in_valid && in_ready) begin
        buf_data[buf_wp] <= in_data;
        buf_wp           <= ~buf_wp;
      end
      if (out_valid && out_ready)
        buf_rp <= ~buf_rp;
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10:   buf_cnt <= buf_cnt + 2'h1;
        2'b01:   buf_cnt <= buf_cnt - 2'h1;
        default: buf_cnt <= buf_cnt;
      endcase
    end
  end

  // Backspace request edge capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bk_prev <= 1'b0;
      bk_pend <= 1'b0;
    end else begin
      bk_prev <= backspace_req;
      if (backspace_req && !bk_prev)
        bk_pend <= 1'b1;
      else if (pn_state == PN_IDLE && bk_pend)
        bk_pend <= 1'b0;
    end
  end

  // Punch and feed cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pn_state       <= PN_IDLE;
      pn_cnt         <= 16'h0000;
      punch_fire     <= 1'b0;
      punch_row      <= '0;
      tape_advance   <= 1'b0;
      tape_backspace <= 1'b0;
      punch_busy     <= 1'b0;
      last_code      <= 8'h00;
    end else begin
      punch_fire     <= 1'b0;
      tape_advance   <= 1'b0;
      tape_backspace <= 1'b0;
      case (pn_state)
        PN_IDLE: begin
          punch_busy <= 1'b0;
          if (bk_pend) begin
            pn_state       <= PN_BACK;
            pn_cnt         <= 16'h0000;
            tape_backspace <= 1'b1;
            punch_busy     <= 1'b1;
          end else if (out_valid) begin
            // Eighth level forced, feed hole always with the row
            punch_row.code <= {1'b1, buf_data[buf_rp][6:0]};
            punch_row.feed <= 1'b1;
            last_code      <= {1'b1, buf_data[buf_rp][6:0]};
            punch_fire     <= 1'b1;
            pn_state       <= PN_PUNCH;
            pn_cnt         <= 16'h0000;
            punch_busy     <= 1'b1;
          end
        end
        PN_PUNCH: begin
          pn_cnt <= pn_cnt + 16'h0001;
          if (pn_cnt == `SSTP_PUNCH_CYC - 16'h0001) begin
            pn_state     <= PN_ADVANCE;
            pn_cnt       <= 16'h0000;
            tape_advance <= 1'b1;
          end
        end
        PN_ADVANCE: begin
          pn_cnt <= pn_cnt + 16'h0001;
          if (pn_cnt == `SSTP_ADV_CYC - 16'h0001)
            pn_state <= PN_IDLE;
        end
        PN_BACK: begin
          pn_cnt <= pn_cnt + 16'h0001;
          if (pn_cnt == `SSTP_BACK_CYC - 16'h0001)
            pn_state <= PN_IDLE;
        end
        default: pn_state <= PN_IDLE;
      endcase
    end
  end

  sequence s_feed_after_punch;
    !tape_advance ##16 tape_advance;
  endsequence

  sequence s_handover;
    (out_valid && out_ready) ##1 punch_fire;
  endsequence

  sequence s_back_done;
    !punch_fire ##16 (pn_state == PN_IDLE);
  endsequence

  property p_one_advance;
    @(posedge clk_sys) disable iff (rst)
      punch_fire |-> s_feed_after_punch;
  endproperty
  a_one_advance: assert property (p_one_advance) else $error("advance not after punch");

  property p_advance_idle;
    @(posedge clk_sys) disable iff (rst)
      tape_advance |-> ##16 (pn_state == PN_IDLE);
  endproperty
  a_advance_idle: assert property (p_advance_idle) else $error("punch stage not stopped");

  // Empty buffer and idle punch: the captured row goes straight through
  property p_handover;
    @(posedge clk_sys) disable iff (rst)
      (in_valid && in_ready && buf_cnt == 2'h0 && pn_state == PN_IDLE && !bk_pend
       && !(backspace_req && !bk_prev)) |=> s_handover;
  endproperty
  a_handover: assert property (p_handover) else $error("captured row not punched");

  property p_back_done;
    @(posedge clk_sys) disable iff (rst)
      tape_backspace |-> s_back_done;
  endproperty
  a_back_done: assert property (p_back_done) else $error("backspace step wrong");

  property p_eighth_mark;
    @(posedge clk_sys) disable iff (rst)
      punch_fire |-> punch_row.code[7] && punch_row.feed;
  endproperty
  a_eighth_mark: assert property (p_eighth_mark) else $error("row missing level 8 or feed");

  property p_idle_mark;
    @(posedge clk_sys) disable iff (rst)
      (rx_state == RX_IDLE && mark) |=> rx_state == RX_IDLE;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("left idle on marking line");

  property p_start;
    @(posedge clk_sys) disable iff (rst)
      (rx_state == RX_IDLE && !mark) |=> rx_state == RX_START;
  endproperty
  a_start: assert property (p_start) else $error("start bit missed");
endmodule : sstp_receiver

// file: verilog/sstp_consts.svh
/*
  Timing counts and fixed values for the start-stop tape punch receiver.
  Assumes a 10 MHz system clock.
*/
`ifndef SSTP_CONSTS_SVH
`define SSTP_CONSTS_SVH

`define SSTP_CLK_HZ          10000000
`define SSTP_UNIT_US         10000
`define SSTP_UNIT_CYC        ((`SSTP_UNIT_US * (`SSTP_CLK_HZ / 1000000)))
`define SSTP_CNT_W           20
`define SSTP_DATA_BITS       4'h8
`define SSTP_STOP_BITS       2'h2
`define SSTP_MARK_LEVEL      1'b1
`define SSTP_FEED_POS        3
`define SSTP_PUNCH_CYC       16'h0010
`define SSTP_ADV_CYC         16'h0010
`define SSTP_BACK_CYC        16'h0010

`endif

// file: verilog/sstp_pkg.sv
/*
  Types for the start-stop tape punch receiver.
  Assumes sstp_consts.svh is included by the design.
*/
package sstp_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } sstp_rx_e;

  typedef enum logic [2:0] {
    PN_IDLE,
    PN_PUNCH,
    PN_ADVANCE,
    PN_BACK
  } sstp_pn_e;

  typedef struct packed {
    logic       feed;
    logic [7:0] code;
  } sstp_row_s;

endpackage : sstp_pkg

// file: testbench/sstp_tx_model.sv
/*
  Remote start-stop transmitter on the current-loop line.
  Assumes the bench calls its tasks; line changes only at falling edges.
*/
`timescale 1ns/1ps

module sstp_tx_model #(
  parameter int UNIT = 20
) (
  input  wire logic clk_sys,
  output logic      line_current
);

  // Closed loop between frames: receiver must stay idle
  initial line_current = 1'b1;

  task automatic send(input logic [7:0] ch, input logic stop_ok);
    logic [10:0] f;
    // Start spacing, data first bit first, first stop set by stop_ok, second stop marking
    f = {1'b1, stop_ok, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clk_sys);
      line_current = f[i];
      repeat (UNIT - 1) @(negedge clk_sys);
    end
  endtask : send

  // Short spacing burst, shorter than half a unit
  task automatic glitch(input int n);
    @(negedge clk_sys);
    line_current = 1'b0;
    repeat (n) @(negedge clk_sys);
    line_current = 1'b1;
  endtask : glitch

endmodule : sstp_tx_model

// file: testbench/sstp_receiver_bench.sv
/*
  Self-checking bench for the tape punch receiver.
  Assumes a unit of 20 clocks so a frame takes 220 cycles.
*/
`timescale 1ns/1ps
`include "sstp_consts.svh"

module sstp_receiver_bench;
  import sstp_pkg::*;

  logic                    clk_sys;
  logic                    rst;
  logic                    line_current;
  logic [`SSTP_CNT_W-1:0]  sp;
  logic                    backspace_req;
  logic                    punch_fire;
  sstp_row_s               punch_row;
  logic                    tape_advance;
  logic                    tape_backspace;
  logic                    rx_busy;
  logic                    punch_busy;
  logic                    frame_error;
  logic [7:0]              last_code;
  sstp_row_s               rows[$];
  int                      cyc;
  int                      fire_cyc;
  int                      n_adv;
  int                      n_back;
  int                      n_fail;
  int                      checks_done;

  sstp_receiver dut (
    .clk_sys(clk_sys), .rst(rst), .line_current(line_current),
    .unit_cycles(20'h00014), .sample_point(sp), .backspace_req(backspace_req),
    .punch_fire(punch_fire), .punch_row(punch_row), .tape_advance(tape_advance),
    .tape_backspace(tape_backspace), .rx_busy(rx_busy), .punch_busy(punch_busy),
    .frame_error(frame_error), .last_code(last_code)
  );

  sstp_tx_model #(.UNIT(20)) tx (.clk_sys(clk_sys), .line_current(line_current));

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  always @(posedge clk_sys) begin
    cyc++;
    if (punch_fire)
      rows.push_back(punch_row);
    if (punch_fire)
      fire_cyc = cyc;
    if (tape_advance) begin
      n_adv++;
      check("advance_gap", 9'(cyc - fire_cyc), 9'h010);
    end
    if (tape_backspace)
      n_back++;
    // Longest expected run is about 29500 cycles
    if (cyc > 60000) begin
      n_fail++;
      results();
    end
  end

  task automatic t_idle();
    repeat (300) @(negedge clk_sys);
    check("idle_rows", 9'(rows.size()), 9'h000);
    check("idle_busy", {8'h00, rx_busy}, 9'h000);
    check("idle_pbusy", {8'h00, punch_busy}, 9'h000);
    $display("test idle done");
  endtask : t_idle

  // All 128 patterns back to back; eighth bit sent spacing on odd ones
  task automatic t_codes();
    for (int i = 0; i < 128; i++)
      tx.send({~i[0], 7'(i)}, 1'b1);
    repeat (60) @(negedge clk_sys);
    check("code_count", 9'(rows.size()), 9'h080);
    for (int i = 0; i < 128; i++)
      check("row", rows[i], {2'b11, 7'(i)});
    check("adv_count", 9'(n_adv), 9'h080);
    check("last_code", {1'b0, last_code}, 9'h0FF);
    check("no_error", {8'h00, frame_error}, 9'h000);
    rows.delete();
    $display("test codes done");
  endtask : t_codes

  // Early sampling instant still reads every bit right
  task automatic t_sample();
    sp = 20'h00005;
    tx.send(8'h96, 1'b1);
    repeat (60) @(negedge clk_sys);
    check("early_row", rows.pop_front(), 9'h196);
    sp = 20'h00000;
    $display("test sample done");
  endtask : t_sample

  task automatic t_glitch();
    tx.glitch(3);
    repeat (300) @(negedge clk_sys);
    check("glitch_rows", 9'(rows.size()), 9'h000);
    $display("test glitch done");
  endtask : t_glitch

  task automatic t_back();
    int a;
    a = n_adv;
    backspace_req = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("back_busy", {8'h00, punch_busy}, 9'h001);
    backspace_req = 1'b0;
    repeat (60) @(negedge clk_sys);
    check("back_count", 9'(n_back), 9'h001);
    check("back_no_adv", 9'(n_adv - a), 9'h000);
    check("back_stopped", {8'h00, punch_busy}, 9'h000);
    $display("test backspace done");
  endtask : t_back

  task automatic t_err();
    tx.send(8'h41, 1'b0);
    repeat (60) @(negedge clk_sys);
    check("frame_error", {8'h00, frame_error}, 9'h001);
    $display("test error done");
  endtask : t_err

  initial begin
    rst = 1'b1;
    sp = 20'h00000;
    backspace_req = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    t_idle();
    t_codes();
    t_sample();
    t_glitch();
    t_back();
    t_err();
    results();
  end

endmodule : sstp_receiver_bench
